// File: rcadc_pkg.sv
package rcadc_pkg;

    // =========================================================
    // register addresses in the data memory space
    localparam logic [7:0] ADDR_CNT_A_HIGH  = 8'h20;
    localparam logic [7:0] ADDR_CNT_A_LOW   = 8'h21;
    localparam logic [7:0] ADDR_TIMER_CTRL  = 8'h22;
    localparam logic [7:0] ADDR_CNT_B_HIGH  = 8'h23;
    localparam logic [7:0] ADDR_CNT_B_LOW   = 8'h24;
    localparam logic [7:0] ADDR_CONV_CTRL   = 8'h25;
    localparam logic [7:0] ADDR_INT_CTRL_1  = 8'h0b;

    // =========================================================
    // converter control fields
    localparam int CONV_OVF_SEL_BIT  = 0;
    localparam int CONV_SELECT_BIT   = 1;
    localparam int CONV_MODE_LSB     = 4;
    localparam logic [7:0] CONV_CTRL_RMASK = 8'hf3;
    localparam logic [7:0] CONV_CTRL_RESET = 8'h00;

    // =========================================================
    // timer control fields
    localparam int TMR_EDGE_BIT      = 3;
    localparam int TMR_RUN_BIT       = 4;
    localparam int TMR_SRC_LSB       = 5;
    localparam logic [7:0] TMR_CTRL_RMASK  = 8'hf8;
    localparam logic [7:0] TMR_CTRL_RESET  = 8'h00;

    // =========================================================
    // interrupt control 1 field
    localparam int INT_TF_BIT        = 4;

    // =========================================================
    // counter A source codes
    localparam logic [2:0] SRC_SYS_CLK   = 3'h0;
    localparam logic [2:0] SRC_INSTR_CLK = 3'h1;
    localparam logic [2:0] SRC_RTC_OUT   = 3'h2;
    localparam logic [2:0] SRC_AD_CLK    = 3'h3;
    localparam logic [2:0] SRC_EVENT     = 3'h4;

    // counter B source codes
    localparam logic [3:0] MODE_CHAN0_IN = 4'h0;
    localparam logic [3:0] MODE_CHAN1_IN = 4'h7;

    // =========================================================
    // widths and counts
    localparam int CNT_W             = 16;
    localparam logic [15:0] CNT_ALL_ONES = 16'hffff;
    localparam logic [15:0] CNT_RESET    = 16'h0000;
    localparam logic [1:0]  INSTR_DIV_LAST = 2'h3;
    localparam int N_PIN_IN          = 4;
    localparam int PIN_RTC           = 0;
    localparam int PIN_CHAN0         = 1;
    localparam int PIN_CHAN1         = 2;
    localparam int PIN_RC_OSC        = 3;

endpackage : rcadc_pkg

// File: rcadc_cnt_if.sv
`timescale 1ns/1ps

interface rcadc_cnt_if;

    logic        load;
    logic [15:0] load_val;
    logic        inc;
    logic [15:0] count;
    logic        ovf;

    modport ctrl (output load, output load_val, output inc,
                  input count, input ovf);
    modport cnt  (input load, input load_val, input inc,
                  output count, output ovf);

endinterface : rcadc_cnt_if

// File: rcadc_counter.sv
`timescale 1ns/1ps

module rcadc_counter
    import rcadc_pkg::*;
(
    // clock and reset
    input  wire logic  mclk,
    input  wire logic  arst_n,
    input  wire logic  ce,
    // counter channel
    rcadc_cnt_if.cnt   port_if
);

    logic [15:0] count_ff;
    logic [15:0] nxt_count;

    // =========================================================
    // 16-bit up counter with parallel load
    assign port_if.ovf   = port_if.inc && (count_ff == CNT_ALL_ONES);
    assign port_if.count = count_ff;
    assign nxt_count     = port_if.load ? port_if.load_val
                         : port_if.inc  ? count_ff + 16'h0001
                         : count_ff;

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            count_ff <= CNT_RESET;
        else if (ce)
            count_ff <= nxt_count;
    end

endmodule : rcadc_counter

// File: rcadc_top.sv
`timescale 1ns/1ps
// How it works
// - converter-select bit 1 turns the counters into converter; else timer.
// - counters A and B are 16-bit up counters from loaded value.
// - in converter mode counter A counts system, instruction or RTC clock.
// - mode field bits 4-7 pick counter B source; 1xxx counts nothing.
// - overflow-select bit 0 picks A or B for interrupt; void in timer mode.
// - setting run bit 4 starts both counters together in converter mode.
// - any converter-mode overflow stops both counters and clears run bit.
// - selected overflow sets timer interrupt flag as counters stop.
// - low-byte writes go only to the shared holding buffer.
// - high-byte write loads high byte plus buffer into counter at once.
// - high-byte read captures live low byte; low-byte read returns buffer.
// - counter byte registers are locked while run bit is set.
// - converter control bits 2 and 3 read as zero.
// - source field 000 system clock, 001 clock/4, 010 RTC output.

module rcadc_top
    import rcadc_pkg::*;
(
    // clock, reset, enable
    input  wire logic       mclk,
    input  wire logic       arst_n,
    input  wire logic       ce,
    // register access
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    // clock pins, asynchronous
    input  wire logic       rtc_clk_in,
    input  wire logic       chan0_clock_input,
    input  wire logic       chan1_clock_input,
    input  wire logic       rc_osc_in,
    // status toward the system
    output logic      [3:0] osc_select,
    output logic            converter_select,
    output logic            run_bit,
    output logic            timer_irq_flag
);

    // =========================================================
    // state
    logic [7:0]  conv_ctrl_ff;
    logic [7:0]  tmr_ctrl_ff;
    logic        tf_ff;
    logic [7:0]  low_buf_ff;
    logic [7:0]  rdata_ff;
    logic [1:0]  div_ff;
    logic [N_PIN_IN-1:0] pin_rise;

    rcadc_cnt_if cnt_a_if ();
    rcadc_cnt_if cnt_b_if ();

    // =========================================================
    // pin synchronisers and rising-edge detect
    genvar gi;
    generate
        for (gi = 0; gi < N_PIN_IN; gi++)
        begin : g_pin
            logic pin_raw;
            logic sync1_ff;
            logic sync2_ff;
            logic prev_ff;
            if (gi == PIN_RTC)
            begin : g_rtc
                assign pin_raw = rtc_clk_in;
            end
            else if (gi == PIN_CHAN0)
            begin : g_c0
                assign pin_raw = chan0_clock_input;
            end
            else if (gi == PIN_CHAN1)
            begin : g_c1
                assign pin_raw = chan1_clock_input;
            end
            else
            begin : g_rc
                assign pin_raw = rc_osc_in;
            end

            // prev resets low like the idle pin: no false edge
            always_ff @(posedge mclk or negedge arst_n)
            begin
                if (!arst_n)
                    sync1_ff <= 1'b0;
                else if (ce)
                    sync1_ff <= pin_raw;
            end

            always_ff @(posedge mclk or negedge arst_n)
            begin
                if (!arst_n)
                    sync2_ff <= 1'b0;
                else if (ce)
                    sync2_ff <= sync1_ff;
            end

            always_ff @(posedge mclk or negedge arst_n)
            begin
                if (!arst_n)
                    prev_ff <= 1'b0;
                else if (ce)
                    prev_ff <= sync2_ff;
            end

            assign pin_rise[gi] = sync2_ff && !prev_ff;
        end
    endgenerate

    // =========================================================
    // control field decode
    wire       conv_mode = conv_ctrl_ff[CONV_SELECT_BIT];
    wire       ovf_sel_b = conv_ctrl_ff[CONV_OVF_SEL_BIT];
    wire [3:0] conv_mode_field = conv_ctrl_ff[CONV_MODE_LSB +: 4];
    wire [2:0] src_sel   = tmr_ctrl_ff[TMR_SRC_LSB +: 3];
    wire       run       = tmr_ctrl_ff[TMR_RUN_BIT];
    // free divider: instruction clock is every fourth mclk
    wire       instr_tick = (div_ff == INSTR_DIV_LAST);

    // counter A source decode
    wire a_src_sys   = (src_sel == SRC_SYS_CLK);
    wire a_src_instr = (src_sel == SRC_INSTR_CLK);
    wire a_src_rtc   = (src_sel == SRC_RTC_OUT);
    wire a_src_event = !conv_mode && (src_sel == SRC_EVENT);
    wire tick_a      = a_src_sys
                    || (a_src_instr && instr_tick)
                    || (a_src_rtc && pin_rise[PIN_RTC])
                    || (a_src_event && pin_rise[PIN_CHAN0]);

    // counter B source decode from converter mode field
    wire b_src_none  = conv_mode_field[3];
    wire b_src_ch0   = (conv_mode_field == MODE_CHAN0_IN);
    wire b_src_ch1   = (conv_mode_field == MODE_CHAN1_IN);
    wire b_src_rc    = !b_src_none && !b_src_ch0 && !b_src_ch1;
    wire tick_b      = (b_src_ch0 && pin_rise[PIN_CHAN0])
                    || (b_src_ch1 && pin_rise[PIN_CHAN1])
                    || (b_src_rc && pin_rise[PIN_RC_OSC]);

    // =========================================================
    // register access decode
    wire sel_a_hi  = (reg_addr == ADDR_CNT_A_HIGH);
    wire sel_a_lo  = (reg_addr == ADDR_CNT_A_LOW);
    wire sel_tmr   = (reg_addr == ADDR_TIMER_CTRL);
    wire sel_b_hi  = (reg_addr == ADDR_CNT_B_HIGH);
    wire sel_b_lo  = (reg_addr == ADDR_CNT_B_LOW);
    wire sel_conv  = (reg_addr == ADDR_CONV_CTRL);
    wire sel_int   = (reg_addr == ADDR_INT_CTRL_1);
    wire cnt_open  = !run;
    wire wr_a_hi   = reg_wr && sel_a_hi && cnt_open;
    wire wr_b_hi   = reg_wr && sel_b_hi && cnt_open;
    wire wr_lo     = reg_wr && (sel_a_lo || sel_b_lo) && cnt_open;
    wire rd_a_hi   = reg_rd && sel_a_hi && cnt_open;
    wire rd_b_hi   = reg_rd && sel_b_hi && cnt_open;
    wire wr_tmr    = reg_wr && sel_tmr;
    wire wr_conv   = reg_wr && sel_conv;
    wire wr_int    = reg_wr && sel_int;

    // =========================================================
    // counting and overflow
    wire cnt_conv  = conv_mode && run;
    wire timer_run = !conv_mode && run;
    wire ovf_a     = cnt_a_if.ovf;
    wire ovf_b     = cnt_b_if.ovf;
    // either overflow stops both, only the selected one flags
    wire conv_stop = cnt_conv && (ovf_a || ovf_b);
    wire conv_irq  = cnt_conv && (ovf_sel_b ? ovf_b : ovf_a);
    wire tmr_irq   = timer_run && ovf_a;
    wire set_tf    = conv_irq || tmr_irq;
    wire [15:0] wr_word = {reg_wdata, low_buf_ff};

    assign cnt_a_if.inc = (cnt_conv || timer_run) && tick_a;
    assign cnt_b_if.inc = cnt_conv && tick_b;
    // timer mode: overflow reloads a from b
    assign cnt_a_if.load = wr_a_hi || tmr_irq || (!conv_mode && wr_b_hi);
    assign cnt_a_if.load_val = tmr_irq ? cnt_b_if.count : wr_word;
    assign cnt_b_if.load = wr_b_hi;
    assign cnt_b_if.load_val = wr_word;

    // =========================================================
    // counter instances
    rcadc_counter u_cnt_a (
        .mclk    (mclk),
        .arst_n  (arst_n),
        .ce      (ce),
        .port_if (cnt_a_if)
    );

    rcadc_counter u_cnt_b (
        .mclk    (mclk),
        .arst_n  (arst_n),
        .ce      (ce),
        .port_if (cnt_b_if)
    );

    // =========================================================
    // next values
    // one buffer shared by both counters
    wire [7:0] nxt_low_buf = wr_lo   ? reg_wdata
                           : rd_a_hi ? cnt_a_if.count[7:0]
                           : rd_b_hi ? cnt_b_if.count[7:0]
                           : low_buf_ff;

    wire [7:0] nxt_conv_ctrl = wr_conv ? (reg_wdata & CONV_CTRL_RMASK)
                                       : conv_ctrl_ff;

    // stop cycle forces run low, even over a write
    wire [7:0] tmr_wr_val  = reg_wdata & TMR_CTRL_RMASK;
    wire [7:0] nxt_tmr_ctrl =
        conv_stop ? ((wr_tmr ? tmr_wr_val : tmr_ctrl_ff)
                     & ~(8'h01 << TMR_RUN_BIT))
        : wr_tmr  ? tmr_wr_val
        : tmr_ctrl_ff;

    // hardware set beats a software clear
    wire       nxt_tf = set_tf ? 1'b1
                      : wr_int ? reg_wdata[INT_TF_BIT]
                      : tf_ff;

    // read data select, unmapped and locked reads give zero
    wire  [7:0] tf_word = 8'(tf_ff) << INT_TF_BIT;
    logic [7:0] rd_mux;

    always_comb
    begin
        rd_mux = 8'h00;
        if (sel_a_hi && cnt_open)
            rd_mux = cnt_a_if.count[15:8];
        else if (sel_b_hi && cnt_open)
            rd_mux = cnt_b_if.count[15:8];
        else if ((sel_a_lo || sel_b_lo) && cnt_open)
            rd_mux = low_buf_ff;
        else if (sel_tmr)
            rd_mux = tmr_ctrl_ff;
        else if (sel_conv)
            rd_mux = conv_ctrl_ff & CONV_CTRL_RMASK;
        else if (sel_int)
            rd_mux = tf_word;
    end

    wire [7:0] nxt_rdata = reg_rd ? rd_mux : rdata_ff;
    wire [1:0] nxt_div   = div_ff + 2'h1;

    // =========================================================
    // control registers
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            conv_ctrl_ff <= CONV_CTRL_RESET;
        else if (ce)
            conv_ctrl_ff <= nxt_conv_ctrl;
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            tmr_ctrl_ff <= TMR_CTRL_RESET;
        else if (ce)
            tmr_ctrl_ff <= nxt_tmr_ctrl;
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            tf_ff <= 1'b0;
        else if (ce)
            tf_ff <= nxt_tf;
    end

    // =========================================================
    // data path registers
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            low_buf_ff <= 8'h00;
        else if (ce)
            low_buf_ff <= nxt_low_buf;
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            rdata_ff <= 8'h00;
        else if (ce)
            rdata_ff <= nxt_rdata;
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            div_ff <= 2'h0;
        else if (ce)
            div_ff <= nxt_div;
    end

    // =========================================================
    // outputs, all from flip-flops
    assign reg_rdata        = rdata_ff;
    assign osc_select       = conv_ctrl_ff[CONV_MODE_LSB +: 4];
    assign converter_select = conv_ctrl_ff[CONV_SELECT_BIT];
    assign run_bit          = tmr_ctrl_ff[TMR_RUN_BIT];
    assign timer_irq_flag   = tf_ff;

endmodule : rcadc_top

// File: rcadc_osc_model.sv
`timescale 1ns/1ps
module rcadc_osc_model #(
    parameter int HP_CH0 = 130,
    parameter int HP_CH1 = 150,
    parameter int HP_RC  = 170
) (
    // gate, clocks idle low while low
    input  wire logic en,
    // oscillator and clock pins
    output logic      chan0_clk,
    output logic      chan1_clk,
    output logic      rc_clk
);
    // =========================================================
    // free-running sources, still between frames
    always
    begin
        chan0_clk = 1'b0;
        wait (en);
        while (en) #HP_CH0 chan0_clk = ~chan0_clk;
    end
    always
    begin
        chan1_clk = 1'b0;
        wait (en);
        while (en) #HP_CH1 chan1_clk = ~chan1_clk;
    end
    always
    begin
        rc_clk = 1'b0;
        wait (en);
        while (en) #HP_RC rc_clk = ~rc_clk;
    end
endmodule : rcadc_osc_model

// File: rcadc_top_monitor.sv
`timescale 1ns/1ps
module rcadc_top_monitor
    import rcadc_pkg::*;
(
    // clock and reset
    input wire logic       mclk,
    input wire logic       arst_n,
    input wire logic       ce,
    // register access
    input wire logic [7:0] reg_addr,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    // status
    input wire logic [3:0] osc_select,
    input wire logic       converter_select,
    input wire logic       run_bit,
    input wire logic       timer_irq_flag
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);
    wire run_wr = ce && reg_wr && reg_addr == ADDR_TIMER_CTRL;
    wire lock_a = reg_addr == ADDR_CNT_A_HIGH || reg_addr == ADDR_CNT_A_LOW;
    wire lock_b = reg_addr == ADDR_CNT_B_HIGH || reg_addr == ADDR_CNT_B_LOW;
    sequence s_stop;
        $fell(run_bit);
    endsequence
    sequence s_locked_rd;
        ce && reg_rd && run_bit && (lock_a || lock_b);
    endsequence
    a_flag_at_stop : assert property
        ($rose(timer_irq_flag) && converter_select |-> s_stop)
        else $error("flag rose without stop");
    a_flag_needs_run : assert property
        ($rose(timer_irq_flag) |-> $past(run_bit))
        else $error("flag rose while stopped");
    a_run_start : assert property
        (run_wr && !run_bit |=> run_bit == $past(reg_wdata[4]))
        else $error("run bit not written");
    a_run_only_sw : assert property
        (!run_bit && !run_wr |=> !run_bit)
        else $error("run bit set by itself");
    a_locked_zero : assert property
        (s_locked_rd |=> reg_rdata == 8'h00)
        else $error("counter read while running");
    a_conv_unused : assert property
        (ce && reg_rd && reg_addr == ADDR_CONV_CTRL |=> reg_rdata[3:2] == 2'h0)
        else $error("unused bits not zero");
    a_conv_fields : assert property
        (ce && reg_wr && reg_addr == ADDR_CONV_CTRL |=>
         converter_select == $past(reg_wdata[1]) &&
         osc_select == $past(reg_wdata[7:4]))
        else $error("converter control not taken");
    a_rdata_hold : assert property
        (!(ce && reg_rd) |=> $stable(reg_rdata))
        else $error("read data moved");
    a_flag_clear : assert property
        (ce && reg_wr && reg_addr == ADDR_INT_CTRL_1 && !reg_wdata[4] &&
         !run_bit |=> !timer_irq_flag)
        else $error("flag not cleared");
endmodule : rcadc_top_monitor

bind rcadc_top rcadc_top_monitor i_mon (.mclk, .arst_n, .ce, .reg_addr,
    .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .osc_select,
    .converter_select, .run_bit, .timer_irq_flag);

// File: rcadc_top_tb_top.sv
`timescale 1ns/1ps
module rcadc_top_tb_top
    import rcadc_pkg::*;
;
    logic       mclk = 1'b0, arst_n = 1'b0, ce = 1'b1, osc_en = 1'b0;
    logic       reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic       rtc, ch0, ch1, rc;
    logic [3:0] osc_select;
    logic       converter_select, run_bit, timer_irq_flag;
    int         errors = 0, n_compared = 0, n;
    assign rtc = 1'b0;
    always #50 mclk = ~mclk;
    rcadc_osc_model i_osc (.en(osc_en), .chan0_clk(ch0), .chan1_clk(ch1),
        .rc_clk(rc));
    rcadc_top i_dut (.mclk, .arst_n, .ce, .reg_addr, .reg_wr, .reg_rd,
        .reg_wdata, .reg_rdata, .rtc_clk_in(rtc), .chan0_clock_input(ch0),
        .chan1_clock_input(ch1), .rc_osc_in(rc), .osc_select,
        .converter_select, .run_bit, .timer_irq_flag);
    // =========================================================
    // access tasks
    task chk(input logic [15:0] s, input logic [15:0] e);
        n_compared++;
        if (s !== e)
        begin
            errors++;
            $display("ERROR %0t: got %h exp %h", $time, s, e);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        #10;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge mclk);
        #10;
        reg_wr = 1'b0;
    endtask : wr
    task rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge mclk);
        #10;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge mclk);
        #10;
        reg_rd = 1'b0;
        chk(reg_rdata, e);
    endtask : rd
    task ld(input logic [7:0] ah, al, bh, bl);
        wr(ADDR_CNT_A_LOW, al);
        wr(ADDR_CNT_A_HIGH, ah);
        wr(ADDR_CNT_B_LOW, bl);
        wr(ADDR_CNT_B_HIGH, bh);
    endtask : ld
    task run_to_stop(input logic [7:0] tmr);
        osc_en = 1'b1;
        wr(ADDR_TIMER_CTRL, tmr);
        n = 1;
        while (run_bit !== 1'b0 && n < 3000)
        begin
            @(posedge mclk);
            #10;
            n++;
        end
        osc_en = 1'b0;
    endtask : run_to_stop
    task final_report;
        $display("errors=%0d compared=%0d", errors, n_compared);
        if (errors == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : final_report
    // =========================================================
    // tests
    initial
    begin
        #2_000_000;
        errors++;
        final_report;
    end
    initial
    begin
        repeat (2) @(posedge mclk);
        #10;
        arst_n = 1'b1;
        rd(ADDR_CONV_CTRL, CONV_CTRL_RESET);
        wr(ADDR_CONV_CTRL, 8'hff);
        rd(ADDR_CONV_CTRL, 8'hf3);
        chk(osc_select, 4'hf);
        chk(converter_select, 1'b1);
        wr(ADDR_TIMER_CTRL, 8'he7);
        rd(ADDR_TIMER_CTRL, 8'he0);
        rd(ADDR_INT_CTRL_1, 8'h00);
        rd(8'h30, 8'h00);
        wr(ADDR_CONV_CTRL, 8'h02);
        ld(8'hff, 8'hf0, 8'h00, 8'h00);
        rd(ADDR_CNT_A_HIGH, 8'hff);
        rd(ADDR_CNT_A_LOW, 8'hf0);
        wr(ADDR_CNT_B_LOW, 8'h77);
        rd(ADDR_CNT_B_HIGH, 8'h00);
        rd(ADDR_CNT_B_LOW, 8'h00);
        run_to_stop(8'h10);
        chk(n >= 15 && n <= 17, 1'b1);
        chk(timer_irq_flag, 1'b1);
        rd(ADDR_CNT_A_HIGH, 8'h00);
        rd(ADDR_CNT_A_LOW, 8'h00);
        rd(ADDR_CNT_B_HIGH, 8'h00);
        wr(ADDR_INT_CTRL_1, 8'h00);
        chk(timer_irq_flag, 1'b0);
        wr(ADDR_CNT_A_LOW, 8'h3c);
        wr(ADDR_CNT_A_HIGH, 8'ha5);
        wr(ADDR_TIMER_CTRL, 8'h50);
        rd(ADDR_CNT_A_HIGH, 8'h00);
        wr(ADDR_CNT_A_HIGH, 8'h00);
        wr(ADDR_TIMER_CTRL, 8'h00);
        rd(ADDR_CNT_A_HIGH, 8'ha5);
        for (int i = 0; i < 8; i++)
        begin
            wr(ADDR_CONV_CTRL, {i[3:0], 4'h3});
            ld(8'h00, 8'h00, 8'hff, 8'hf8);
            run_to_stop(8'h50);
            chk(timer_irq_flag, 1'b1);
            rd(ADDR_CNT_B_HIGH, 8'h00);
            rd(ADDR_CNT_B_LOW, 8'h00);
            rd(ADDR_CNT_A_HIGH, 8'h00);
            wr(ADDR_INT_CTRL_1, 8'h00);
        end
        wr(ADDR_CONV_CTRL, 8'h83);
        ld(8'hff, 8'hf0, 8'hff, 8'hf8);
        run_to_stop(8'h30);
        chk(n >= 60 && n <= 68, 1'b1);
        chk(timer_irq_flag, 1'b0);
        rd(ADDR_CNT_B_HIGH, 8'hff);
        rd(ADDR_CNT_B_LOW, 8'hf8);
        wr(ADDR_CONV_CTRL, 8'h00);
        wr(ADDR_CNT_B_LOW, 8'h11);
        wr(ADDR_CNT_B_HIGH, 8'h22);
        rd(ADDR_CNT_A_HIGH, 8'h22);
        wr(ADDR_CONV_CTRL, 8'h01);
        wr(ADDR_CNT_B_LOW, 8'hfc);
        wr(ADDR_CNT_B_HIGH, 8'hff);
        osc_en = 1'b1;
        wr(ADDR_TIMER_CTRL, 8'h90);
        repeat (20) @(posedge mclk);
        #10;
        chk(run_bit, 1'b1);
        chk(timer_irq_flag, 1'b1);
        osc_en = 1'b0;
        wr(ADDR_TIMER_CTRL, 8'h00);
        rd(ADDR_CNT_A_HIGH, 8'hff);
        rd(ADDR_CNT_B_HIGH, 8'hff);
        final_report;
    end
endmodule : rcadc_top_tb_top
